// ---- common/scp_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the clock controller
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ****************************************
// Register word offsets (byte addresses)
// ****************************************
`define SCP_OFF_TRIM      4'h0
`define SCP_OFF_DIVCTL    4'h4
`define SCP_OFF_ASYNC     4'h8
`define SCP_OFF_STATUS    4'hc

// ****************************************
// Field positions
// ****************************************
`define SCP_DIVCTL_PCE    7
`define SCP_ASYNC_EXTIN   0
`define SCP_ASYNC_TOSCEN  1
`define SCP_TRIM_RANGE    7

// ****************************************
// Codes and reset values
// ****************************************
`define SCP_CLOCK_SOURCE_SELECT_FUSES_EXT     4'h0
`define SCP_CLOCK_SOURCE_SELECT_FUSES_RC8     4'h2
`define SCP_CLOCK_SOURCE_SELECT_FUSES_RC128   4'h3
`define SCP_CLOCK_SOURCE_SELECT_FUSES_LFXT0   4'h6
`define SCP_CLOCK_SOURCE_SELECT_FUSES_LFXT1   4'h7
`define SCP_DIV_RST_DIV8  4'h3
`define SCP_DIV_RST_DIV1  4'h0
`define SCP_DIV_MAX_CODE  4'h8

// ****************************************
// Timing
// ****************************************
`define SCP_CLK_PERIOD_NS 10
`define SCP_BASE_CK       14
`define SCP_WAKE_CK       6
`define SCP_PCE_WINDOW    4
`define SCP_TOSC_MIN_RATIO 4
`define SCP_T_4MS_US      4000
`define SCP_T_4P1MS_US    4100
`define SCP_T_64MS_US     64000
`define SCP_T_65MS_US     65000
`define SCP_US_TO_CYC(us) ((((us) * 1000) + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)

`endif

// ---- common/scp_pkg.sv ----
// Purpose: Types shared by the clock controller files
// Assumes: Nothing
// Notes:   Numbers live in scp_defs.svh
package scp_pkg;

  // Static fuse straps, sampled at reset
  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_delay_fuses;
    logic       clock_output_fuse;
    logic       reset_pin_disable_fuse;
    logic       divide_by_eight_fuse;
  } scp_fuse_t;

  // Gated clock enables of the synchronous domains
  typedef struct packed {
    logic io;
    logic adc;
    logic cpu;
    logic flash;
  } scp_clk_en_t;

  typedef enum logic [2:0] {
    SCP_SRC_EXT,
    SCP_SRC_RC8,
    SCP_SRC_RC128,
    SCP_SRC_LFXT,
    SCP_SRC_NONE
  } scp_src_t;

  typedef enum logic [1:0] {
    SCP_ST_RST_DLY,
    SCP_ST_RUN,
    SCP_ST_SLEEP,
    SCP_ST_WAKE_DLY
  } scp_state_t;

endpackage

// ---- rtl/scp_prescaler.sv ----
// Purpose: Glitch-free power-of-two divider of the master clock
// Assumes: Select changes are adopted only at a period boundary
// Notes:   Reserved codes divide by 256
`timescale 1ns/1ns
`default_nettype none
`include "scp_defs.svh"

module scp_prescaler #(
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Setting
  input  wire logic [3:0]       init_i,
  input  wire logic [3:0]       sel_i,
  // Divided outputs
  output logic                  tick_o,
  output logic                  clk_o
);

  logic [3:0]       cur_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W:0]   div;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] half;
  logic [3:0]       eff;

  if (CNT_W != 8) begin : g_chk
    $error("scp_prescaler: CNT_W must be 8");
  end

  always_comb begin
    eff  = (cur_q > `SCP_DIV_MAX_CODE) ? `SCP_DIV_MAX_CODE : cur_q;
    div  = (CNT_W+1)'(1) << eff;
    last = CNT_W'(div - (CNT_W+1)'(1));
    half = CNT_W'(div >> 1);
  end

  // Period counter; new setting taken only at wrap, so no short pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      cur_q <= init_i;
    end else if (ce_i) begin
      if (cnt_q >= last) begin
        cnt_q <= '0;
        cur_q <= sel_i;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
      clk_o  <= 1'b0;
    end else if (ce_i) begin
      tick_o <= (cnt_q >= last);
      clk_o  <= (div == (CNT_W+1)'(1)) ? 1'b1 : (cnt_q < half);
    end
  end

endmodule // scp_prescaler

`default_nettype wire

// ---- rtl/scp_clock_ctrl.sv ----
// Purpose: System clock source select, start-up delay, prescaler control and trim registers
// Assumes: clk_i is the selected master clock; fuses are static straps
// Notes:   Classic Wishbone slave, one-cycle ack
`timescale 1ns/1ns
`default_nettype none
`include "scp_defs.svh"

module scp_clock_ctrl
  import scp_pkg::*;
#(
  parameter int unsigned DLY_4MS_CYC   = `SCP_US_TO_CYC(`SCP_T_4MS_US),
  parameter int unsigned DLY_4P1MS_CYC = `SCP_US_TO_CYC(`SCP_T_4P1MS_US),
  parameter int unsigned DLY_64MS_CYC  = `SCP_US_TO_CYC(`SCP_T_64MS_US),
  parameter int unsigned DLY_65MS_CYC  = `SCP_US_TO_CYC(`SCP_T_65MS_US),
  parameter int unsigned DLY_W         = 23
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Straps
  input  wire scp_fuse_t   fuse_i,
  input  wire logic [7:0]  factory_trim_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Sleep control
  input  wire logic        sleep_i,
  input  wire logic        wake_i,
  // Timer oscillator pin
  input  wire logic        timer_osc_input_pin_i,
  // Clock source and oscillator control
  output scp_src_t         src_sel_o,
  output logic [7:0]       osc_trim_o,
  output logic             timer_osc_en_o,
  output logic             timer_ext_clk_sel_o,
  // Clock gating and pin
  output scp_clk_en_t      clk_en_o,
  output logic             core_ready_o,
  output logic             clock_out_pin_o,
  output logic             clock_out_pin_oe_n_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (DLY_W > 31 || DLY_65MS_CYC + `SCP_BASE_CK >= (1 << DLY_W) ||
      DLY_64MS_CYC + `SCP_BASE_CK >= (1 << DLY_W)) begin : g_chk
    $error("scp_clock_ctrl: DLY_W too narrow for the delay counts");
  end

  // ****************************************
  // Fuse sampling
  // ****************************************
  scp_fuse_t fuse_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_q <= fuse_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_sel_o <= SCP_SRC_NONE;
    end else if (ce_i) begin
      unique case (fuse_q.clock_source_select_fuses)
        `SCP_CLOCK_SOURCE_SELECT_FUSES_RC128: src_sel_o <= SCP_SRC_RC128;
        `SCP_CLOCK_SOURCE_SELECT_FUSES_EXT:   src_sel_o <= SCP_SRC_EXT;
        `SCP_CLOCK_SOURCE_SELECT_FUSES_RC8:   src_sel_o <= SCP_SRC_RC8;
        `SCP_CLOCK_SOURCE_SELECT_FUSES_LFXT0,
        `SCP_CLOCK_SOURCE_SELECT_FUSES_LFXT1: src_sel_o <= SCP_SRC_LFXT;
        default:          src_sel_o <= SCP_SRC_NONE;
      endcase
    end
  end

  // ****************************************
  // Start-up delay
  // ****************************************
  scp_state_t       state_q;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] rst_dly;
  logic             is_rc128;

  always_comb begin
    is_rc128 = (fuse_q.clock_source_select_fuses == `SCP_CLOCK_SOURCE_SELECT_FUSES_RC128);
    unique case (fuse_q.startup_delay_fuses)
      2'b00: rst_dly = fuse_q.reset_pin_disable_fuse
                     ? DLY_W'(`SCP_BASE_CK + DLY_4P1MS_CYC)
                     : DLY_W'(`SCP_BASE_CK);
      2'b01: rst_dly = is_rc128 ? DLY_W'(`SCP_BASE_CK + DLY_4MS_CYC)
                                : DLY_W'(`SCP_BASE_CK + DLY_4P1MS_CYC);
      default: rst_dly = is_rc128 ? DLY_W'(`SCP_BASE_CK + DLY_64MS_CYC)
                                  : DLY_W'(`SCP_BASE_CK + DLY_65MS_CYC);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q      <= SCP_ST_RST_DLY;
      dly_q        <= '0;
      core_ready_o <= 1'b0;
    end else if (ce_i) begin
      unique case (state_q)
        SCP_ST_RST_DLY: begin
          if (dly_q >= rst_dly - DLY_W'(1)) begin
            state_q      <= SCP_ST_RUN;
            dly_q        <= '0;
            core_ready_o <= 1'b1;
          end else begin
            dly_q <= dly_q + DLY_W'(1);
          end
        end
        SCP_ST_RUN: begin
          if (sleep_i) begin
            state_q      <= SCP_ST_SLEEP;
            core_ready_o <= 1'b0;
          end
        end
        SCP_ST_SLEEP: begin
          if (wake_i) begin
            state_q <= SCP_ST_WAKE_DLY;
            dly_q   <= '0;
          end
        end
        SCP_ST_WAKE_DLY: begin
          if (dly_q >= DLY_W'(`SCP_WAKE_CK - 1)) begin
            state_q      <= SCP_ST_RUN;
            dly_q        <= '0;
            core_ready_o <= 1'b1;
          end else begin
            dly_q <= dly_q + DLY_W'(1);
          end
        end
      endcase
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic       req;
  logic       wr;
  logic [7:0] rd_byte;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & wb_ack_o & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // Trim register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_trim_o <= factory_trim_i;
    end else if (ce_i && wr && wb_adr_i == `SCP_OFF_TRIM) begin
      osc_trim_o <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // Divide control with timed unlock
  // ****************************************
  logic [3:0] div_sel_q;
  logic [3:0] div_init;
  logic       pce_q;
  logic [2:0] pce_cnt_q;
  logic       wr_div;
  logic       pce_set;
  logic       sel_wr;

  assign div_init = fuse_i.divide_by_eight_fuse ? `SCP_DIV_RST_DIV8 : `SCP_DIV_RST_DIV1;
  assign wr_div   = wr && wb_adr_i == `SCP_OFF_DIVCTL;
  assign pce_set  = wr_div && wb_dat_i[`SCP_DIVCTL_PCE] && wb_dat_i[6:0] == 7'h00;
  assign sel_wr   = wr_div && !wb_dat_i[`SCP_DIVCTL_PCE] && pce_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pce_q     <= 1'b0;
      pce_cnt_q <= 3'h0;
    end else if (ce_i) begin
      if (sel_wr) begin
        pce_q     <= 1'b0;
        pce_cnt_q <= 3'h0;
      end else if (pce_q) begin
        pce_cnt_q <= pce_cnt_q - 3'h1;
        if (pce_cnt_q == 3'h1) begin
          pce_q <= 1'b0;
        end
      end else if (pce_set) begin
        pce_q     <= 1'b1;
        pce_cnt_q <= 3'(`SCP_PCE_WINDOW);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_sel_q <= div_init;
    end else if (ce_i && sel_wr) begin
      div_sel_q <= wb_dat_i[3:0];
    end
  end

  // ****************************************
  // Timer oscillator control
  // ****************************************
  logic       ext_in_q;
  logic       tosc_en_q;
  logic [2:0] tosc_sync_q;
  logic       tosc_lvl_q;
  logic [2:0] tosc_gap_q;
  logic       tosc_fast_q;
  logic       sys_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_in_q  <= 1'b0;
      tosc_en_q <= 1'b0;
    end else if (ce_i && wr && wb_adr_i == `SCP_OFF_ASYNC) begin
      ext_in_q  <= wb_dat_i[`SCP_ASYNC_EXTIN];
      tosc_en_q <= wb_dat_i[`SCP_ASYNC_TOSCEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_osc_en_o      <= 1'b0;
      timer_ext_clk_sel_o <= 1'b0;
    end else if (ce_i) begin
      timer_osc_en_o      <= tosc_en_q && fuse_q.clock_source_select_fuses == `SCP_CLOCK_SOURCE_SELECT_FUSES_RC8;
      timer_ext_clk_sel_o <= ext_in_q;
    end
  end

  // Pin synchroniser; level updates once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tosc_sync_q <= 3'h0;
      tosc_lvl_q  <= 1'b0;
    end else if (ce_i) begin
      tosc_sync_q <= {tosc_sync_q[1:0], timer_osc_input_pin_i};
      if (tosc_sync_q[1] == tosc_sync_q[2]) begin
        tosc_lvl_q <= tosc_sync_q[2];
      end
    end
  end

  // Flags a timer clock faster than a quarter of the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tosc_gap_q  <= 3'h0;
      tosc_fast_q <= 1'b0;
    end else if (ce_i) begin
      if (!timer_osc_en_o) begin
        tosc_gap_q <= 3'h0;
      end else if (tosc_sync_q[2] && tosc_sync_q[1] && !tosc_lvl_q) begin
        if (tosc_gap_q < 3'(`SCP_TOSC_MIN_RATIO)) begin
          tosc_fast_q <= 1'b1;
        end
        tosc_gap_q <= 3'h0;
      end else if (sys_tick && tosc_gap_q < 3'(`SCP_TOSC_MIN_RATIO)) begin
        tosc_gap_q <= tosc_gap_q + 3'h1;
      end
      if (wr && wb_adr_i == `SCP_OFF_STATUS && wb_dat_i[0]) begin
        if (!(tosc_sync_q[2] && tosc_sync_q[1] && !tosc_lvl_q)) begin
          tosc_fast_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    unique case (wb_adr_i)
      `SCP_OFF_TRIM:   rd_byte = osc_trim_o;
      `SCP_OFF_DIVCTL: rd_byte = {pce_q, 3'h0, div_sel_q};
      `SCP_OFF_ASYNC:  rd_byte = {6'h00, tosc_en_q, ext_in_q};
      `SCP_OFF_STATUS: rd_byte = {2'b00, src_sel_o, core_ready_o, timer_osc_en_o, tosc_fast_q};
      default:         rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Prescaler and clock distribution
  // ****************************************
  logic presc_clk;

  scp_prescaler #(
    .CNT_W (8)
  ) u_presc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .init_i (div_init),
    .sel_i  (div_sel_q),
    .tick_o (sys_tick),
    .clk_o  (presc_clk)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_o <= '0;
    end else if (ce_i) begin
      clk_en_o <= {4{sys_tick & core_ready_o}};
    end
  end

  // Clock pin is held low in reset; its output enable follows the fuse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_out_pin_o      <= 1'b0;
      clock_out_pin_oe_n_o <= ~fuse_i.clock_output_fuse;
    end else if (ce_i) begin
      clock_out_pin_o      <= presc_clk & fuse_q.clock_output_fuse;
      clock_out_pin_oe_n_o <= ~fuse_q.clock_output_fuse;
    end
  end

endmodule // scp_clock_ctrl

`default_nettype wire

// ---- tb/scp_clock_ctrl_monitor.sv ----
// Purpose: Port checker of the clock controller
// Assumes: One clock domain, fuses static while out of reset
// Notes:   Delay parameters are handed on by the bind
`timescale 1ns/1ns
`default_nettype none
module scp_clock_ctrl_monitor
  import scp_pkg::*;
#(
  parameter int unsigned DLY_4MS_CYC   = 20,
  parameter int unsigned DLY_4P1MS_CYC = 21,
  parameter int unsigned DLY_64MS_CYC  = 40,
  parameter int unsigned DLY_65MS_CYC  = 41
) (
  // Clock and straps
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire scp_fuse_t   fuse_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Outputs
  input wire scp_src_t    src_sel_o,
  input wire logic [7:0]  osc_trim_o,
  input wire logic        timer_osc_en_o,
  input wire scp_clk_en_t clk_en_o,
  input wire logic        core_ready_o,
  input wire logic        clock_out_pin_o,
  input wire logic        clock_out_pin_oe_n_o
);
  // ****************************************
  // Expected delay and source
  // ****************************************
  int unsigned     cnt_q;
  int unsigned     dly;
  logic            seen_q;
  scp_src_t        src;
  wire logic [3:0] cks = fuse_i.clock_source_select_fuses;
  wire logic [7:0] wd  = wb_dat_i[7:0];

  always_comb begin
    case (fuse_i.startup_delay_fuses)
      2'b00: dly = 14 + (fuse_i.reset_pin_disable_fuse ? DLY_4P1MS_CYC : 0);
      2'b01: dly = 14 + (cks == 4'h3 ? DLY_4MS_CYC : DLY_4P1MS_CYC);
      default: dly = 14 + (cks == 4'h3 ? DLY_64MS_CYC : DLY_65MS_CYC);
    endcase
    case (cks)
      4'h0: src = SCP_SRC_EXT;
      4'h2: src = SCP_SRC_RC8;
      4'h3: src = SCP_SRC_RC128;
      4'h6, 4'h7: src = SCP_SRC_LFXT;
      default: src = SCP_SRC_NONE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 1;
      seen_q <= seen_q | core_ready_o;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RST_DLY: assert property ($rose(core_ready_o) && !seen_q |-> cnt_q + 1 >= dly && cnt_q <= dly + 1)
    else $error("reset delay off");
  AST_CLKEN_EQ: assert property (clk_en_o.io == clk_en_o.adc && clk_en_o.cpu == clk_en_o.flash && clk_en_o.io == clk_en_o.cpu)
    else $error("domain enables differ");
  AST_CLKEN_IDLE: assert property (!core_ready_o && !$past(core_ready_o) |-> clk_en_o == '0)
    else $error("enable while core held");
  AST_CLOCK_OUTPUT_FUSE_DRV: assert property (clock_out_pin_oe_n_o == !fuse_i.clock_output_fuse)
    else $error("clock pin enable wrong");
  AST_CLOCK_OUTPUT_FUSE_OFF: assert property (!fuse_i.clock_output_fuse |-> !clock_out_pin_o)
    else $error("clock pin active unfused");
  AST_SRC: assert property (core_ready_o |-> src_sel_o == src)
    else $error("source decode wrong");
  AST_TOSC_RC: assert property (timer_osc_en_o |-> cks == 4'h2)
    else $error("timer oscillator off RC");
  AST_TRIM_WR: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 4'h0 |-> ##2 osc_trim_o == $past(wd, 2))
    else $error("trim write lost");

  COV_READY: cover property ($rose(core_ready_o));
  COV_TOSC: cover property (timer_osc_en_o);
  COV_DIV_WR: cover property (wb_ack_o && wb_we_i && wb_adr_i == 4'h4);
endmodule // scp_clock_ctrl_monitor

bind scp_clock_ctrl scp_clock_ctrl_monitor #(
  .DLY_4MS_CYC(DLY_4MS_CYC), .DLY_4P1MS_CYC(DLY_4P1MS_CYC), .DLY_64MS_CYC(DLY_64MS_CYC), .DLY_65MS_CYC(DLY_65MS_CYC)
) u_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .fuse_i(fuse_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .src_sel_o(src_sel_o),
  .osc_trim_o(osc_trim_o), .timer_osc_en_o(timer_osc_en_o), .clk_en_o(clk_en_o), .core_ready_o(core_ready_o),
  .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe_n_o(clock_out_pin_oe_n_o)
);
`default_nettype wire

// ---- tb/scp_tosc_src.sv ----
// Purpose: Clock applied to the timer oscillator pin
// Assumes: Rate unrelated to the master clock
// Notes:   Holds its level while disabled
`timescale 1ns/1ns
`default_nettype none
module scp_tosc_src #(
  parameter int HALF_NS = 43
) (
  // Control
  input  wire logic en_i,
  // Pin
  output logic      pin_o
);
  // Fixed rate, no step between cycles
  initial begin
    pin_o = 1'b0;
    forever begin
      #(HALF_NS);
      if (en_i) pin_o = ~pin_o;
    end
  end
endmodule // scp_tosc_src
`default_nettype wire

// ---- tb/scp_clock_ctrl_tb.sv ----
// Purpose: Self-checking bench of the clock controller
// Assumes: Short reset delays, bench model of the registers
// Notes:   Ends through complete_run
`timescale 1ns/1ns
`default_nettype none
module scp_clock_ctrl_tb;
  import scp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        slp = 1'b0;
  logic        wak = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  sel = 4'h1;
  logic [3:0]  wsel = 4'h1;
  logic        ten = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [7:0]  ftrim = 8'h0;
  logic [7:0]  r;
  scp_fuse_t   fuse = '0;
  int          fail_count = 0;
  int          checks_done = 0;
  int          tmo = 0;
  int          m_sel;
  wire logic [31:0] dat_o;
  wire logic [7:0]  trim;
  wire logic        ack, tosc, text, rdy, pin, cko, cko_oe_n;
  wire scp_src_t    so;
  wire scp_clk_en_t cen;
  // {source, startup, out, rstdis, div8}
  scp_fuse_t ft[5] = '{9'h069, 9'h014, 9'h0c3, 9'h0f8, 9'h045};
  scp_src_t  xs[5] = '{SCP_SRC_RC128, SCP_SRC_EXT, SCP_SRC_LFXT, SCP_SRC_LFXT, SCP_SRC_RC8};

  scp_clock_ctrl #(.DLY_4MS_CYC(20), .DLY_4P1MS_CYC(21), .DLY_64MS_CYC(40), .DLY_65MS_CYC(41)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .fuse_i(fuse), .factory_trim_i(ftrim),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_i(slp), .wake_i(wak), .timer_osc_input_pin_i(pin),
    .src_sel_o(so), .osc_trim_o(trim), .timer_osc_en_o(tosc), .timer_ext_clk_sel_o(text),
    .clk_en_o(cen), .core_ready_o(rdy), .clock_out_pin_o(cko), .clock_out_pin_oe_n_o(cko_oe_n));
  scp_tosc_src #(.HALF_NS(43)) u_tosc (.en_i(ten), .pin_o(pin));

  always #5 clk_i = ~clk_i;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= wsel;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    chk(32'(dat_o[31:8]), 32'h0);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(32'(r), 32'(e));
  endtask

  task automatic set_div(input logic [7:0] c);
    bus(1'b1, 4'h4, 8'h80);
    bus(1'b1, 4'h4, c);
  endtask

  task automatic per(output int p);
    @(posedge clk_i);
    while (cen.io !== 1'b1) @(posedge clk_i);
    p = 0;
    do begin
      @(posedge clk_i);
      p++;
    end while (cen.io !== 1'b1);
  endtask

  task automatic reset_dut(input scp_fuse_t f);
    int n;
    @(posedge clk_i);
    rst_i <= 1'b1;
    fuse  <= f;
    ftrim <= 8'($urandom());
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  always @(posedge clk_i) begin
    tmo++;
    if (tmo == 40000) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int p;
    int n;
    logic [7:0] t;
    void'($urandom(32'h894a9276));
    for (int i = 0; i < 5; i++) begin
      reset_dut(ft[i]);
      m_sel = ft[i].divide_by_eight_fuse ? 3 : 0;
      chk(32'(rdy), 32'h1);
      chk(32'(so), 32'(xs[i]));
      chk(32'(cko_oe_n), 32'(!ft[i].clock_output_fuse));
      rd(4'h0, ftrim);
      rd(4'h4, 8'(m_sel));
      bus(1'b0, 4'hc, 8'h00);
      chk(32'(r[5:3]), 32'(xs[i]));
    end
    $display("fuse test done");
    t = 8'($urandom());
    bus(1'b1, 4'h0, t);
    bus(1'b1, 4'h1, ~t);
    wsel = 4'h0;
    bus(1'b1, 4'h0, ~t);
    wsel = 4'h1;
    rd(4'h0, t);
    chk(32'(trim), 32'(t));
    rd(4'h2, 8'h00);
    $display("trim test done");
    bus(1'b1, 4'h4, 8'h81);
    bus(1'b1, 4'h4, 8'h05);
    rd(4'h4, 8'(m_sel));
    bus(1'b1, 4'h4, 8'h80);
    repeat (4) @(posedge clk_i);
    bus(1'b1, 4'h4, 8'h05);
    rd(4'h4, 8'(m_sel));
    set_div(8'h80);
    bus(1'b1, 4'h4, 8'h05);
    rd(4'h4, 8'(m_sel));
    bus(1'b1, 4'h4, 8'h80);
    rd(4'h4, 8'h80 | 8'(m_sel));
    $display("unlock test done");
    for (int c = 0; c < 16; c++) begin
      set_div(8'(c));
      m_sel = c;
      rd(4'h4, 8'(m_sel));
      per(p);
      per(p);
      chk(32'(p), 32'h1 << (c > 8 ? 8 : c));
    end
    $display("divider test done");
    ten <= 1'b1;
    bus(1'b1, 4'h8, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(32'(text), 32'h1);
    chk(32'(tosc), 32'h1);
    repeat (3000) @(posedge clk_i);
    rd(4'hc, 8'h0f);
    set_div(8'h00);
    repeat (600) @(posedge clk_i);
    bus(1'b1, 4'hc, 8'h01);
    repeat (50) @(posedge clk_i);
    rd(4'hc, 8'h0e);
    $display("timer test done");
    bus(1'b1, 4'h4, 8'h80);
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce <= 1'b1;
    bus(1'b1, 4'h4, 8'h01);
    m_sel = 1;
    rd(4'h4, 8'(m_sel));
    n = 0;
    repeat (16) begin
      @(posedge clk_i);
      n += (cko === 1'b1) ? 1 : 0;
    end
    chk(32'(n), 32'h8);
    chk(32'(cko_oe_n), 32'h0);
    $display("freeze test done");
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(rdy), 32'h0);
    wak <= 1'b1;
    @(posedge clk_i);
    wak <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(rdy), 32'h0);
    @(posedge clk_i);
    chk(32'(rdy), 32'h1);
    $display("sleep test done");
    complete_run();
  end
endmodule // scp_clock_ctrl_tb
`default_nettype wire
